// >>> src/disk_power_mode_controller.sv
/*
 * Power-mode controller: active/idle/standby/sleep state machine, standby
 * timer, standby/sleep completion sequence, adaptive idle sub-modes, APM
 * level handling and linear address mapping, reached over Avalon-MM.
 * Assumes the mechanics answer flush_done, unload_done and spindle_stopped
 * as levels on the same clock, and an option strap on an async pin.
 */
// The address map and the Avalon-MM slave port were decided locally.

// What this block does
// RQ1 - Linear address equals (cyl*heads+head)*sectors+sector-1 for current geometry.
// RQ2 - Sleep command makes interface inactive; only reset leaves sleep, into standby.
// RQ3 - Idle commands go to idle at once; plain idle loads and starts timer.
// RQ4 - Standby commands go to standby at once; plain standby loads timer. Here standby is entered only after the flush and unload steps.
// RQ5 - Check-mode reports standby, entering standby or leaving standby.
// RQ6 - Standby/sleep completion: flush, unload, status, irq, brake, wait stop, post.
// RQ7 - No command within timer period in active or idle enters standby.
// RQ8 - Zero sector count sets the standby period to 109 minutes.
// RQ9 - Ready set in active, idle, standby; any command accepted when not busy.
// RQ10 - Host neither reads status nor issues commands while device sleeps.
// RQ11 - Idle and standby show busy clear, ready set; media off in standby, sleep.
// RQ12 - Registers and interrupt stay valid two seconds after sleep completes.
// RQ13 - Host should not read status before soft reset that wakes sleep.
// RQ14 - After power-on or hard reset enter idle or standby per option.
// RQ15 - APM level accepted from 01h to FEh, handled in bands.
// RQ16 - APM enabled and disabled by separate set-features subcommands.
// RQ17 - With APM and timer, standby on whichever comes first.
// RQ18 - Identify word 83 bit 3 shows support; word 91 shows current level.
// RQ19 - After active processing enter performance idle, all electronics powered.
// RQ20 - Active idle parks head mid-disk without servo; about 20 ms recovery.
// RQ21 - Low power idle unloads heads, spindle spinning; about 300 ms recovery.
// RQ22 - Idle delays chosen adaptively from inter-command intervals, bounded by level.
// RQ23 - Any host command restarts the standby inactivity count.
module disk_power_mode_controller #(
	parameter longint unsigned unit_cyc = pwr_mode_pkg::timer_unit_cyc,
	parameter longint unsigned hold_cyc = pwr_mode_pkg::sleep_hold_cyc,
	parameter longint unsigned act_rec_cyc = pwr_mode_pkg::active_idle_cyc,
	parameter longint unsigned low_rec_cyc = pwr_mode_pkg::low_idle_cyc
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic soft_reset,
	input wire logic standby_option_pin,
	input wire pwr_mode_pkg::av_req_t av_req,
	output logic [31:0] av_readdata,
	output logic av_waitrequest,
	output logic intrq,
	input wire logic flush_done,
	input wire logic unload_done,
	input wire logic spindle_stopped,
	output pwr_mode_pkg::mech_t mech
);
	import pwr_mode_pkg::*;

	typedef enum logic [2:0] {
		seq_none, seq_flush, seq_unload, seq_irq, seq_brake, seq_post
	} seq_t;

	logic rst_s1_q, rst_n_q;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	logic [2:0] opt_q, opt_d;
	logic [1:0] fill_q, fill_d;
	logic strap_ok;
	// Strap counts only once all three stages hold pin samples
	always_comb begin
		opt_d = {opt_q[1:0], standby_option_pin};
		fill_d = (fill_q == 2'h3) ? fill_q : fill_q + 2'h1;
	end
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			opt_q <= 3'h0;
			fill_q <= 2'h0;
		end else if (clk_en) begin
			opt_q <= opt_d;
			fill_q <= fill_d;
		end
	end
	assign strap_ok = fill_q == 2'h3 && opt_q[2] == opt_q[1];

	pmode_t mode_q, mode_d;
	idle_sub_t sub_q, sub_d;
	seq_t seq_q, seq_d;
	logic seq_sleep_q, seq_sleep_d;
	logic busy_q, busy_d, intrq_q, intrq_d, strap_done_q, strap_done_d;
	logic apm_en_q, apm_en_d;
	logic [7:0] apm_lvl_q, apm_lvl_d, answer_q, answer_d, err_q, err_d;
	logic [15:0] timer_units_q, timer_units_d, left_units_q, left_units_d;
	logic timer_on_q, timer_on_d;
	logic [39:0] unit_cnt_q, unit_cnt_d, idle_cnt_q, idle_cnt_d;
	logic [39:0] gap_avg_q, gap_avg_d, since_cmd_q, since_cmd_d;
	logic [39:0] hold_cnt_q, hold_cnt_d;
	logic regs_valid_q, regs_valid_d;
	logic [23:0] lba_out_q, lba_out_d;
	logic [7:0] heads_q, heads_d, spt_q, spt_d;
	logic [31:0] rdata_q, rdata_d;
	logic ack_q, ack_d;

	logic access, wr_cmd, accept;
	logic [7:0] opcode, count, feat;
	logic [39:0] delay_lim, to_act, to_low;
	assign access = (av_req.read || av_req.write) && !ack_q;
	assign opcode = av_req.writedata[7:0];
	assign count = av_req.writedata[15:8];
	assign feat = av_req.writedata[23:16];
	assign wr_cmd = access && av_req.write && av_req.address == reg_cmd;
	// RQ9 any command if not busy
	assign accept = wr_cmd && !busy_q && mode_q != m_sleep;
	// RQ22 bound from level band
	assign delay_lim = 40'(apm_lvl_q[7] ? act_rec_cyc : low_rec_cyc);
	assign to_act = (gap_avg_q > delay_lim) ? delay_lim : gap_avg_q;
	assign to_low = to_act << 3;

	always_comb begin
		mode_d = mode_q;
		sub_d = sub_q;
		seq_d = seq_q;
		seq_sleep_d = seq_sleep_q;
		busy_d = busy_q;
		intrq_d = intrq_q;
		strap_done_d = strap_done_q | strap_ok;
		apm_en_d = apm_en_q;
		apm_lvl_d = apm_lvl_q;
		answer_d = answer_q;
		err_d = err_q;
		timer_units_d = timer_units_q;
		left_units_d = left_units_q;
		timer_on_d = timer_on_q;
		unit_cnt_d = unit_cnt_q;
		idle_cnt_d = idle_cnt_q;
		gap_avg_d = gap_avg_q;
		// Saturates so a long quiet spell cannot wrap the interval history
		since_cmd_d = (since_cmd_q == '1) ? since_cmd_q : since_cmd_q + 40'h1;
		hold_cnt_d = hold_cnt_q;
		regs_valid_d = regs_valid_q;
		lba_out_d = lba_out_q;
		heads_d = heads_q;
		spt_d = spt_q;
		// RQ14 option picks start mode
		if (!strap_done_q && strap_ok) mode_d = opt_q[2] ? m_standby : m_idle;
		// Timer pauses while a completion sequence runs
		// RQ7 timer in active or idle
		if (timer_on_q && (mode_q == m_active || mode_q == m_idle) && seq_q == seq_none) begin
			if (unit_cnt_q >= unit_cyc - 1) begin
				unit_cnt_d = '0;
				left_units_d = left_units_q - 16'h1;
				if (left_units_q <= 16'h1) begin
					mode_d = m_standby;
					left_units_d = timer_units_q;
				end
			end else unit_cnt_d = unit_cnt_q + 40'h1;
		end
		// RQ19 sub-modes while idle
		if (mode_q == m_idle && seq_q == seq_none) begin
			idle_cnt_d = idle_cnt_q + 40'h1;
			// RQ20 enter active idle
			if (apm_en_q && sub_q == idle_perf && idle_cnt_q >= to_act) sub_d = idle_act;
			// RQ21 enter low power idle
			if (apm_en_q && sub_q == idle_act && idle_cnt_q >= to_low) sub_d = idle_low;
			// RQ17 algorithm standby
			if (apm_en_q && apm_lvl_q < 8'h80 && sub_q == idle_low && idle_cnt_q >= to_low << 2)
				mode_d = m_standby;
		end
		// RQ12 hold window
		if (mode_q == m_sleep && regs_valid_q) begin
			if (hold_cnt_q >= hold_cyc - 1) regs_valid_d = 1'b0;
			else hold_cnt_d = hold_cnt_q + 40'h1;
		end
		// RQ6 completion order
		unique case (seq_q)
			seq_none: ;
			seq_flush: if (flush_done) seq_d = seq_unload;
			seq_unload: if (unload_done) seq_d = seq_irq;
			seq_irq: begin
				busy_d = 1'b0;
				intrq_d = 1'b1;
				seq_d = seq_brake;
				if (seq_sleep_q) begin
					// RQ2 interface off after sleep
					mode_d = m_sleep;
					regs_valid_d = 1'b1;
					hold_cnt_d = '0;
				end else mode_d = m_standby;
			end
			seq_brake: if (spindle_stopped) seq_d = seq_post;
			seq_post: seq_d = seq_none;
			default: seq_d = seq_none;
		endcase
		// Status read clears intrq and wins over a completion in the same cycle
		if (access && av_req.read && av_req.address == reg_status) intrq_d = 1'b0;
		if (access && av_req.write && av_req.address == reg_geom) begin
			heads_d = av_req.writedata[7:0];
			spt_d = av_req.writedata[15:8];
		end
		if (access && av_req.write && av_req.address == reg_lba_in) begin
			// RQ1 linear mapping
			lba_out_d = 24'((({8'h0, av_req.writedata[15:0]} * heads_q + av_req.writedata[23:16])
				* spt_q) + av_req.writedata[31:24] - 24'h1);
		end
		if (accept) begin
			// RQ23 restart on command
			unit_cnt_d = '0;
			left_units_d = timer_units_q;
			// RQ22 interval history
			gap_avg_d = gap_avg_q - (gap_avg_q >> 2) + (since_cmd_q >> 2);
			since_cmd_d = '0;
			idle_cnt_d = '0;
			sub_d = idle_perf;
			err_d = 8'h00;
			intrq_d = 1'b1;
			unique case (opcode)
				op_idle, op_idle_imm: begin
					// RQ3 idle now
					mode_d = m_idle;
					if (opcode == op_idle) begin
						// RQ8 zero count default
						timer_units_d = (count == 8'h00) ? default_timer_units : {8'h0, count};
						left_units_d = timer_units_d;
						timer_on_d = 1'b1;
					end
				end
				op_standby, op_standby_imm, op_sleep: begin
					// RQ4 standby after the flush and unload steps
					if (opcode == op_standby) begin
						timer_units_d = (count == 8'h00) ? default_timer_units : {8'h0, count};
						left_units_d = timer_units_d;
					end
					busy_d = 1'b1;
					intrq_d = 1'b0;
					seq_sleep_d = opcode == op_sleep;
					seq_d = seq_flush;
				end
				op_check_mode: begin
					// RQ5 report standby state
					if (seq_q != seq_none) answer_d = ans_entering;
					else if (mode_q == m_standby) answer_d = ans_standby;
					else answer_d = ans_active;
				end
				op_set_features: begin
					// Abort code for a refused level or subcommand
					// RQ16 separate subcommands
					if (feat == feat_apm_on) begin
						// RQ15 range check
						if (count >= apm_level_min && count <= apm_level_max) begin
							apm_en_d = 1'b1;
							apm_lvl_d = count;
						end else err_d = 8'h04;
					end else if (feat == feat_apm_off) begin
						apm_en_d = 1'b0;
						apm_lvl_d = 8'h00;
					end else err_d = 8'h04;
				end
				default: mode_d = m_idle;
			endcase
			if (mode_q == m_standby && opcode != op_check_mode && mode_d != m_standby)
				answer_d = ans_leaving;
		end
		// RQ2 soft reset wakes into standby
		if (soft_reset && mode_q == m_sleep) begin
			mode_d = m_standby;
			seq_d = seq_none;
			busy_d = 1'b0;
			intrq_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q <= m_idle;
			sub_q <= idle_perf;
			seq_q <= seq_none;
			seq_sleep_q <= 1'b0;
			busy_q <= 1'b0;
			intrq_q <= 1'b0;
			strap_done_q <= 1'b0;
			apm_en_q <= 1'b0;
			apm_lvl_q <= 8'h00;
			answer_q <= ans_active;
			err_q <= 8'h01;
			timer_units_q <= 16'h0;
			left_units_q <= 16'h0;
			timer_on_q <= 1'b0;
			unit_cnt_q <= '0;
			idle_cnt_q <= '0;
			gap_avg_q <= '0;
			since_cmd_q <= '0;
			hold_cnt_q <= '0;
			regs_valid_q <= 1'b1;
			lba_out_q <= 24'h0;
			heads_q <= 8'h10;
			spt_q <= 8'h3f;
		end else if (clk_en) begin
			mode_q <= mode_d;
			sub_q <= sub_d;
			seq_q <= seq_d;
			seq_sleep_q <= seq_sleep_d;
			busy_q <= busy_d;
			intrq_q <= intrq_d;
			strap_done_q <= strap_done_d;
			apm_en_q <= apm_en_d;
			apm_lvl_q <= apm_lvl_d;
			answer_q <= answer_d;
			err_q <= err_d;
			timer_units_q <= timer_units_d;
			left_units_q <= left_units_d;
			timer_on_q <= timer_on_d;
			unit_cnt_q <= unit_cnt_d;
			idle_cnt_q <= idle_cnt_d;
			gap_avg_q <= gap_avg_d;
			since_cmd_q <= since_cmd_d;
			hold_cnt_q <= hold_cnt_d;
			regs_valid_q <= regs_valid_d;
			lba_out_q <= lba_out_d;
			heads_q <= heads_d;
			spt_q <= spt_d;
		end
	end

	// Bus answer: one wait cycle then data
	// Side effects land at the request edge; waitrequest only paces the master
	always_comb begin
		ack_d = access;
		rdata_d = 32'h0;
		if (access && av_req.read) begin
			unique case (av_req.address)
				// RQ11 status per mode
				reg_status: rdata_d = {16'h0, err_q, busy_q,
					mode_q != m_sleep && !busy_q, 1'b0, mode_q != m_sleep && !busy_q, 4'h0};
				reg_config: rdata_d = {21'h0, timer_on_q, 3'h0, sub_q, 1'b0, mode_q, 1'b0};
				reg_cmd: rdata_d = {24'h0, answer_q};
				reg_lba_out: rdata_d = {8'h0, lba_out_q};
				reg_geom: rdata_d = {16'h0, spt_q, heads_q};
				// RQ18 identify words
				reg_ident: rdata_d = {8'h0, apm_lvl_q, 8'h0, id83_low};
				reg_mech: rdata_d = {26'h0, mech};
				default: rdata_d = 32'h0;
			endcase
			// Past the hold window the registers read as zero
			if (mode_q == m_sleep && !regs_valid_q) rdata_d = 32'h0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else if (clk_en) begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign av_waitrequest = !ack_q;
	assign av_readdata = rdata_q;
	assign intrq = intrq_q && (mode_q != m_sleep || regs_valid_q);

	// Media, heads and servo follow the mode, all off while a sequence runs
	always_comb begin
		mech.iface_active = mode_q != m_sleep;
		mech.media_on = (mode_q == m_active || mode_q == m_idle) && seq_q == seq_none;
		mech.spindle_on = mech.media_on || seq_q == seq_flush || seq_q == seq_unload;
		mech.heads_loaded = mech.media_on && !(mode_q == m_idle && sub_q == idle_low);
		mech.servo_on = mech.heads_loaded && !(mode_q == m_idle && sub_q == idle_act);
		mech.brake = seq_q == seq_brake;
	end
endmodule // disk_power_mode_controller

// >>> shared/pwr_mode_pkg.sv
/*
 * Shared constants and types for the disk power-mode controller: register map,
 * command codes, mode encodings and timing counts.
 * Assumes a 200 MHz clock and a 32-bit Avalon-MM slave port.
 */
package pwr_mode_pkg;
	localparam int unsigned clk_mhz = 200;

	// Register byte offsets
	localparam logic [5:0] reg_cmd = 6'h00;
	localparam logic [5:0] reg_status = 6'h04;
	localparam logic [5:0] reg_config = 6'h08;
	localparam logic [5:0] reg_lba_in = 6'h0c;
	localparam logic [5:0] reg_lba_out = 6'h10;
	localparam logic [5:0] reg_geom = 6'h14;
	localparam logic [5:0] reg_ident = 6'h18;
	localparam logic [5:0] reg_mech = 6'h1c;

	// Command opcodes (cmd register bits 7:0, sector count 15:8, feature 23:16)
	localparam logic [7:0] op_standby_imm = 8'he0;
	localparam logic [7:0] op_idle_imm = 8'he1;
	localparam logic [7:0] op_standby = 8'he2;
	localparam logic [7:0] op_idle = 8'he3;
	localparam logic [7:0] op_check_mode = 8'he5;
	localparam logic [7:0] op_sleep = 8'he6;
	localparam logic [7:0] op_set_features = 8'hef;
	localparam logic [7:0] feat_apm_on = 8'h05;
	localparam logic [7:0] feat_apm_off = 8'h85;
	localparam logic [7:0] apm_level_min = 8'h01;
	localparam logic [7:0] apm_level_max = 8'hfe;

	// Check-mode answer codes
	localparam logic [7:0] ans_standby = 8'h00;
	localparam logic [7:0] ans_entering = 8'h40;
	localparam logic [7:0] ans_leaving = 8'h41;
	localparam logic [7:0] ans_active = 8'hff;

	// Status and identify bit positions
	localparam int unsigned st_busy = 7;
	localparam int unsigned st_ready = 6;
	localparam int unsigned st_seek_done = 4;
	localparam int unsigned id83_apm_bit = 3;
	localparam logic [7:0] id83_low = 8'h08;

	// Timing
	localparam int unsigned timer_unit_s = 5;
	localparam int unsigned default_timer_min = 109;
	localparam int unsigned sleep_hold_s = 2;
	localparam int unsigned active_idle_rec_ms = 20;
	localparam int unsigned low_idle_rec_ms = 300;
	localparam longint unsigned cyc_per_s = longint'(clk_mhz) * 1000000;
	localparam longint unsigned timer_unit_cyc = cyc_per_s * timer_unit_s;
	localparam logic [15:0] default_timer_units = 16'(default_timer_min * 60 / timer_unit_s);
	localparam longint unsigned sleep_hold_cyc = cyc_per_s * sleep_hold_s;
	localparam longint unsigned active_idle_cyc = cyc_per_s / 1000 * active_idle_rec_ms;
	localparam longint unsigned low_idle_cyc = cyc_per_s / 1000 * low_idle_rec_ms;

	typedef enum logic [2:0] {
		m_active, m_idle, m_standby, m_sleep
	} pmode_t;

	typedef enum logic [1:0] {
		idle_perf, idle_act, idle_low
	} idle_sub_t;

	typedef struct packed {
		logic write;
		logic read;
		logic [5:0] address;
		logic [31:0] writedata;
	} av_req_t;

	typedef struct packed {
		logic media_on;
		logic heads_loaded;
		logic servo_on;
		logic spindle_on;
		logic brake;
		logic iface_active;
	} mech_t;
endpackage

// >>> bench/disk_power_mode_props.sv
/* Port assertions for the power-mode controller.
   Assumes binding into the controller, sharing its hold_cyc parameter. */
module disk_power_mode_props #(
	parameter longint unsigned hold_cyc = 50
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic soft_reset,
	input wire logic standby_option_pin,
	input wire pwr_mode_pkg::av_req_t av_req,
	input wire logic [31:0] av_readdata,
	input wire logic av_waitrequest,
	input wire logic intrq,
	input wire logic flush_done,
	input wire logic unload_done,
	input wire logic spindle_stopped,
	input wire pwr_mode_pkg::mech_t mech
);
	timeunit 1ns;
	timeprecision 100ps;
	import pwr_mode_pkg::*;
	logic [7:0] slp_q, slp_d;
	logic st_rd, id_rd;
	// Cycles spent with the interface inactive, saturating
	always_comb begin
		slp_d = 8'h00;
		if (!mech.iface_active) slp_d = slp_q + {7'h00, slp_q != 8'hff};
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) slp_q <= 8'h00;
		else slp_q <= slp_d;
	end
	assign st_rd = av_req.read && av_req.address == reg_status && !av_waitrequest;
	assign id_rd = av_req.read && av_req.address == reg_ident && !av_waitrequest;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	ready_on_read_a: assert property (st_rd && mech.iface_active |-> av_readdata[st_ready])
		else $error("ready bit clear while interface active");
	ident_support_a: assert property (id_rd |-> av_readdata[7:0] == id83_low)
		else $error("identify support bit wrong");
	sleep_stays_a: assert property (!mech.iface_active && !soft_reset |=> !mech.iface_active)
		else $error("left sleep without reset");
	sleep_wake_a: assert property ($rose(soft_reset) && !mech.iface_active && clk_en
		|-> ##[1:4] (mech.iface_active && !mech.media_on))
		else $error("wake from sleep not into standby");
	sleep_media_a: assert property (!mech.iface_active |-> !mech.media_on)
		else $error("media active with interface inactive");
	brake_after_irq_a: assert property ($rose(mech.brake) |-> intrq || $past(intrq))
		else $error("brake before completion interrupt");
	brake_unloaded_a: assert property (mech.brake |-> !mech.heads_loaded && !mech.media_on)
		else $error("brake with heads loaded");
	brake_release_a: assert property (mech.brake && spindle_stopped |-> ##[1:4] !mech.brake)
		else $error("brake held after spindle stop");
	servo_heads_a: assert property (mech.servo_on |-> mech.heads_loaded && mech.spindle_on)
		else $error("servo running without loaded heads");
	irq_hold_a: assert property ($fell(mech.iface_active) |-> intrq [*8])
		else $error("interrupt lost early in sleep");
	irq_mask_a: assert property (slp_q > hold_cyc + 4 |-> !intrq)
		else $error("interrupt still shown after hold window");
	sleep_c: cover property ($fell(mech.iface_active));
	brake_c: cover property ($rose(mech.brake));
	wake_c: cover property ($rose(soft_reset) && !mech.iface_active);
endmodule // disk_power_mode_props

bind disk_power_mode_controller disk_power_mode_props #(.hold_cyc(hold_cyc)) props (
	.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .soft_reset(soft_reset),
	.standby_option_pin(standby_option_pin), .av_req(av_req), .av_readdata(av_readdata),
	.av_waitrequest(av_waitrequest), .intrq(intrq), .flush_done(flush_done),
	.unload_done(unload_done), .spindle_stopped(spindle_stopped), .mech(mech)
);

// >>> bench/mech_model.sv
/* Behavioural drive mechanics facing the controller: cache flush once not dirty, head unload
   and spindle stop, the last two answered promptly or slowly.
   Assumes mech outputs are levels on ref_clk. */
module mech_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic dirty,
	input wire pwr_mode_pkg::mech_t mech,
	output logic flush_done,
	output logic unload_done,
	output logic spindle_stopped
);
	timeunit 1ns;
	timeprecision 100ps;
	import pwr_mode_pkg::*;
	logic [4:0] ul_q, ul_d, st_q, st_d, lim;
	logic stop_q, stop_d;
	always_comb begin
		lim = slow ? 5'h14 : 5'h02;
		ul_d = mech.heads_loaded ? 5'h00 : ul_q + {4'h0, ul_q != lim};
		st_d = mech.brake ? st_q + {4'h0, st_q != lim} : 5'h00;
		stop_d = stop_q;
		if (mech.brake && st_q == lim) stop_d = 1'b1;
		else if (mech.spindle_on && !mech.brake) stop_d = 1'b0;
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ul_q <= 5'h00;
			st_q <= 5'h00;
			stop_q <= 1'b0;
		end else begin
			ul_q <= ul_d;
			st_q <= st_d;
			stop_q <= stop_d;
		end
	end
	assign flush_done = !dirty;
	assign unload_done = !mech.heads_loaded && ul_q == lim;
	assign spindle_stopped = stop_q;
endmodule // mech_model

// >>> bench/disk_power_mode_controller_test.sv
/* Register-level bench for the power-mode controller.
   Assumes the mechanics model on the far side and a 200 MHz clock. */
module disk_power_mode_controller_test;
	timeunit 1ns;
	timeprecision 100ps;
	import pwr_mode_pkg::*;
	localparam int unit = 10;
	logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, soft_reset = 1'b0, strap = 1'b0;
	logic slow = 1'b0, dirty = 1'b0;
	logic av_waitrequest, intrq, flush_done, unload_done, spindle_stopped;
	logic [31:0] av_readdata, q;
	av_req_t av_req = '0;
	mech_t mech;
	int errors = 0, tests_run = 0;
	logic [15:0] lcyl [3] = '{16'h0000, 16'h0002, 16'hffff};
	logic [7:0] lhd [3] = '{8'h00, 8'h03, 8'h03};
	logic [7:0] lsec [3] = '{8'h01, 8'h05, 8'h0a};
	logic [7:0] lvl [3] = '{apm_level_min, 8'h80, apm_level_max};

	disk_power_mode_controller #(.unit_cyc(unit), .hold_cyc(50), .act_rec_cyc(4),
		.low_rec_cyc(8)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
		.soft_reset(soft_reset), .standby_option_pin(strap), .av_req(av_req),
		.av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .intrq(intrq),
		.flush_done(flush_done), .unload_done(unload_done),
		.spindle_stopped(spindle_stopped), .mech(mech));
	mech_model mech_far (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow), .dirty(dirty),
		.mech(mech), .flush_done(flush_done), .unload_done(unload_done),
		.spindle_stopped(spindle_stopped));

	initial forever #2.5 ref_clk = ~ref_clk;

	task automatic test_done();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		av_req <= '{write: wr, read: !wr, address: a, writedata: d};
		// Looked at between edges: what the next rising edge will sample
		do begin
			@(negedge ref_clk);
			n++;
			done = av_waitrequest === 1'b0;
			q = av_readdata;
			@(posedge ref_clk);
		end while (!done && n < 40);
		av_req <= '0;
		@(posedge ref_clk);
		if (!done) begin
			errors++;
			test_done();
		end
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q & m, exp);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] feat);
		bus(1'b1, reg_cmd, {8'h00, feat, cnt, op});
	endtask
	task automatic wait_mode(input pmode_t m);
		int n;
		n = 0;
		do begin
			bus(1'b0, reg_config, 32'h0);
			n++;
		end while (q[3:1] !== m && n < 80);
		chk({29'h0, q[3:1]}, {29'h0, m});
		if (q[3:1] !== m) test_done();
	endtask
	task automatic wait_irq();
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		do begin
			@(negedge ref_clk);
			n++;
			seen = intrq;
		end while (seen !== 1'b1 && n < 300);
		chk({31'h0, seen}, 32'h1);
		@(posedge ref_clk);
		if (seen !== 1'b1) test_done();
	endtask

	initial begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		wait_mode(m_idle);
		rdc(reg_geom, 32'hffff, 32'h3f10);
		bus(1'b1, reg_lba_in, 32'h0100_0001);
		rdc(reg_lba_out, 32'hffffff, 32'h3f0);
		bus(1'b1, reg_geom, 32'h0a04);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, reg_lba_in, {lsec[i], lhd[i], lcyl[i]});
			rdc(reg_lba_out, 32'hffffff, (lcyl[i] * 4 + lhd[i]) * 10 + lsec[i] - 1);
		end
		rdc(6'h20, 32'hffffffff, 32'h0);
		for (int i = 0; i < 3; i++) begin
			cmd(op_set_features, lvl[i], feat_apm_on);
			rdc(reg_ident, 32'hff00ff, {8'h00, lvl[i], 8'h00, id83_low});
		end
		cmd(op_check_mode, 8'h00, 8'h00);
		rdc(reg_config, 32'h60, 32'h0);
		cmd(op_set_features, 8'h00, feat_apm_off);
		rdc(reg_ident, 32'hff0000, 32'h0);
		dirty <= 1'b1;
		cmd(op_standby_imm, 8'h00, 8'h00);
		repeat (10) @(posedge ref_clk);
		chk({31'h0, intrq}, 32'h0);
		dirty <= 1'b0;
		wait_irq();
		wait_mode(m_standby);
		chk({31'h0, mech.media_on}, 32'h0);
		rdc(reg_status, 32'hd0, 32'h50);
		chk({31'h0, intrq}, 32'h0);
		cmd(op_check_mode, 8'h00, 8'h00);
		rdc(reg_cmd, 32'hff, {24'h0, ans_standby});
		cmd(op_idle_imm, 8'h00, 8'h00);
		wait_mode(m_idle);
		rdc(reg_cmd, 32'hff, {24'h0, ans_leaving});
		rdc(reg_config, 32'h400, 32'h0);
		cmd(op_check_mode, 8'h00, 8'h00);
		rdc(reg_cmd, 32'hff, {24'h0, ans_active});
		slow <= 1'b1;
		cmd(op_standby, 8'h04, 8'h00);
		wait_mode(m_standby);
		cmd(op_check_mode, 8'h00, 8'h00);
		rdc(reg_cmd, 32'hff, {24'h0, ans_entering});
		cmd(op_idle, 8'h04, 8'h00);
		rdc(reg_config, 32'h40e, 32'h402);
		repeat (35) @(posedge ref_clk);
		cmd(op_check_mode, 8'h00, 8'h00);
		repeat (20) @(posedge ref_clk);
		rdc(reg_config, 32'he, 32'h2);
		wait_mode(m_standby);
		cmd(op_idle, 8'h00, 8'h00);
		// Frozen cycles must not count towards the standby period
		clk_en <= 1'b0;
		repeat (100) @(posedge ref_clk);
		clk_en <= 1'b1;
		repeat (int'(default_timer_units) * unit - 50) @(posedge ref_clk);
		rdc(reg_config, 32'he, 32'h2);
		wait_mode(m_standby);
		slow <= 1'b0;
		cmd(op_idle_imm, 8'h00, 8'h00);
		wait_mode(m_idle);
		cmd(op_sleep, 8'h00, 8'h00);
		wait_irq();
		repeat (4) @(posedge ref_clk);
		chk({31'h0, mech.iface_active}, 32'h0);
		// No register access while asleep, wake by soft reset only
		repeat (60) @(posedge ref_clk);
		soft_reset <= 1'b1;
		@(posedge ref_clk);
		soft_reset <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk({31'h0, mech.iface_active}, 32'h1);
		wait_mode(m_standby);
		strap <= 1'b1;
		reset_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		wait_mode(m_standby);
		test_done();
	end
endmodule // disk_power_mode_controller_test
